// ### shared/pcu_pkg.sv
// Package with register map, field layouts and reset values of the port control unit
package pcu_pkg;
  localparam int PCU_PORTS = 4;
  localparam int PCU_PINS = 16;
  localparam logic [31:0] PCU_BASE_ADDR = 32'h4000_1000;
  localparam logic [31:0] PCU_BANK_STRIDE = 32'h0000_0100;
  localparam logic [7:0] PCU_OFS_FUNC = 8'h00;
  localparam logic [7:0] PCU_OFS_TYPE = 8'h04;
  localparam logic [7:0] PCU_OFS_PULLUP = 8'h08;
  localparam logic [7:0] PCU_OFS_DEBOUNCE = 8'h0C;
  localparam logic [7:0] PCU_OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] PCU_OFS_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] PCU_OFS_IRQ_TRIG = 8'h18;
  localparam logic [7:0] PCU_OFS_DBCLK = 8'h1C;
  localparam logic [12:0] PCU_OFS_ACCESS_EN = 13'h1FF0;
  // Function selector codes
  localparam logic [1:0] PCU_FN_GPIO = 2'h0;
  localparam logic [1:0] PCU_FN_ALT1 = 2'h1;
  localparam logic [1:0] PCU_FN_ALT2 = 2'h2;
  localparam logic [1:0] PCU_FN_ALT3 = 2'h3;
  // Signal type codes
  localparam logic [1:0] PCU_TY_PUSHPULL = 2'h0;
  localparam logic [1:0] PCU_TY_OPENDRAIN = 2'h1;
  localparam logic [1:0] PCU_TY_INPUT = 2'h2;
  localparam logic [1:0] PCU_TY_ANALOG = 2'h3;
  // Trigger codes in the trigger register, two bits a pin
  localparam logic [1:0] PCU_TRIG_RISE = 2'h0;
  localparam logic [1:0] PCU_TRIG_FALL = 2'h1;
  localparam logic [1:0] PCU_TRIG_BOTH = 2'h2;
  localparam logic [1:0] PCU_TRIG_LEVEL = 2'h3;
  // Debounce clock source codes
  localparam logic [2:0] PCU_DBSRC_BUS = 3'h4;
  localparam logic [2:0] PCU_DBSRC_XTAL = 3'h6;
  localparam int PCU_DBSRC_LSB = 8;
  localparam int PCU_DBDIV_LSB = 0;
  localparam logic [31:0] PCU_DBCLK_MASK = 32'h0000_07FF;
  // Reset values per port A..D
  localparam logic [31:0] PCU_FUNC_RST_A = 32'h0000_0000;
  localparam logic [31:0] PCU_FUNC_RST_B = 32'h0000_0000;
  localparam logic [31:0] PCU_FUNC_RST_C = 32'h0050_0155;
  localparam logic [31:0] PCU_FUNC_RST_D = 32'h0000_0000;
  localparam logic [31:0] PCU_TYPE_RST_ANALOG = 32'hFFFF_FFFF;
  localparam logic [31:0] PCU_TYPE_RST_C = 32'hAAAA_AAAA;
  localparam logic [31:0] PCU_DBCLK_RST = 32'h0000_0001;
  localparam logic [31:0] PCU_ACCESS_RST = 32'h0000_0000;
  localparam logic [31:0] PCU_ACCESS_KEY = 32'h0000_0015;
  // Debounce samples that must agree
  localparam int PCU_DEB_SAMPLES = 3;
endpackage : pcu_pkg

// ### core/pcu_divider.sv
// Debounce sample tick generator: source select and N divider
`timescale 1ns/10ps
module pcu_divider
  import pcu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source ticks
  input wire logic ring_tick,
  input wire logic xtal_tick,
  // Setup
  input wire logic [2:0] src_sel,
  input wire logic [7:0] div_n,
  // Output
  output logic tick
);
  logic src_tick;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic wrap;
  logic tick_q;

  // 0xx ring, 100 bus clock, 110 crystal, others stop
  assign src_tick = !src_sel[2] ? ring_tick :
                    (src_sel == PCU_DBSRC_BUS) ? 1'b1 :
                    (src_sel == PCU_DBSRC_XTAL) ? xtal_tick : 1'b0;
  assign wrap = src_tick && (cnt_q >= div_n);
  assign cnt_d = wrap ? 8'h00 : (src_tick ? cnt_q + 8'h01 : cnt_q);
  assign tick = tick_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end
endmodule : pcu_divider

// ### core/pcu_pin.sv
// One pin: debounce filter and interrupt event detection
`timescale 1ns/10ps
module pcu_pin
  import pcu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pad and setup
  input wire logic pad_in,
  input wire logic deb_en,
  input wire logic deb_tick,
  input wire logic [1:0] trig,
  // Results
  output logic filt,
  output logic event_pulse
);
  logic [PCU_DEB_SAMPLES-1:0] hist_q;
  logic stable_q;
  logic prev_q;
  logic agree_hi;
  logic agree_lo;
  logic stable_d;
  logic rise;
  logic fall;

  assign agree_hi = &hist_q;
  assign agree_lo = ~|hist_q;
  assign stable_d = !deb_en ? pad_in :
                    agree_hi ? 1'b1 : (agree_lo ? 1'b0 : stable_q);
  assign filt = stable_q;
  assign rise = stable_q && !prev_q;
  assign fall = !stable_q && prev_q;
  assign event_pulse = (trig == PCU_TRIG_RISE) ? rise :
                       (trig == PCU_TRIG_FALL) ? fall :
                       (trig == PCU_TRIG_BOTH) ? (rise || fall) : stable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= '0;
      stable_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      if (deb_tick) begin
        hist_q <= {hist_q[PCU_DEB_SAMPLES-2:0], pad_in};
      end
      stable_q <= stable_d;
      prev_q <= stable_q;
    end
  end
endmodule : pcu_pin

// ### core/pcu_top.sv
// Port control unit: four 16-pin ports with mux, type, pull-up, debounce and interrupts
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module pcu_top
  import pcu_pkg::*;
#(
  parameter int NPORTS = PCU_PORTS,
  parameter int NPINS = PCU_PINS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port enables from clock control
  input wire logic [NPORTS-1:0] port_enable,
  input wire logic [NPORTS-1:0] port_clk_enable,
  // Debounce source ticks
  input wire logic ring_tick,
  input wire logic xtal_tick,
  // Pads
  input wire logic [NPORTS*NPINS-1:0] pad_in,
  output logic [NPORTS*NPINS-1:0] pad_out,
  output logic [NPORTS*NPINS-1:0] pad_oe,
  output logic [NPORTS*NPINS-1:0] pad_pullup,
  output logic [NPORTS*NPINS-1:0] pad_analog,
  // Peripheral side
  output logic [NPORTS*NPINS*2-1:0] pin_function,
  input wire logic [NPORTS*NPINS*3-1:0] alt_out,
  input wire logic [NPORTS*NPINS*3-1:0] alt_oe,
  input wire logic [NPORTS*NPINS-1:0] gpio_out,
  output logic [NPORTS*NPINS-1:0] pin_in,
  // Interrupt
  output logic irq
);
  logic [NPORTS-1:0][31:0] func_q;
  logic [NPORTS-1:0][31:0] type_q;
  logic [NPORTS-1:0][NPINS-1:0] pull_q;
  logic [NPORTS-1:0][NPINS-1:0] deb_q;
  logic [NPORTS-1:0][NPINS-1:0] ien_q;
  logic [NPORTS-1:0][NPINS-1:0] iflag_q;
  logic [NPORTS-1:0][31:0] trig_q;
  logic [NPORTS-1:0][31:0] dbclk_q;
  logic [31:0] access_q;
  logic [31:0] prdata_q;
  logic [NPORTS-1:0][NPINS-1:0] evt;
  logic [NPORTS-1:0][31:0] rd_port;
  logic [NPORTS-1:0] tick;

  // Address decode
  wire setup_ph = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire [31:0] rel_addr = paddr - PCU_BASE_ADDR;
  wire in_banks = (paddr >= PCU_BASE_ADDR) && (rel_addr < 32'h0000_0400);
  wire [1:0] bank = rel_addr[9:8];
  wire [7:0] ofs = rel_addr[7:0];
  wire hit_access = (paddr >= PCU_BASE_ADDR) && (rel_addr[12:0] == PCU_OFS_ACCESS_EN) &&
                    (rel_addr[31:13] == 19'h0);
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire hit_known = (ofs <= PCU_OFS_DBCLK) && (ofs[1:0] == 2'b00);
  wire unmapped = !(in_banks && hit_known) && !hit_access;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = prdata_q;

  // Reads register during setup so data stands in the access phase
  wire [31:0] rd_mux = hit_access ? access_q :
                       (in_banks && hit_known) ? rd_port[bank] : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_q <= PCU_ACCESS_RST;
    end else if (wr_en && hit_access) begin
      access_q <= merge(access_q, pwdata, wmask);
    end
  end

  genvar p;
  genvar b;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      localparam logic [31:0] FUNC_RST = (p == 0) ? PCU_FUNC_RST_A : (p == 1) ? PCU_FUNC_RST_B :
                                         (p == 2) ? PCU_FUNC_RST_C : PCU_FUNC_RST_D;
      localparam logic [31:0] TYPE_RST = (p == 2) ? PCU_TYPE_RST_C : PCU_TYPE_RST_ANALOG;
      wire wr_bank = wr_en && in_banks && (bank == 2'(p));
      wire [NPINS-1:0] wlo = pwdata[NPINS-1:0] & wmask[NPINS-1:0];
      wire port_on = port_enable[p] && port_clk_enable[p];

      assign rd_port[p] = (ofs == PCU_OFS_FUNC) ? func_q[p] :
                          (ofs == PCU_OFS_TYPE) ? type_q[p] :
                          (ofs == PCU_OFS_PULLUP) ? {16'h0000, pull_q[p]} :
                          (ofs == PCU_OFS_DEBOUNCE) ? {16'h0000, deb_q[p]} :
                          (ofs == PCU_OFS_IRQ_EN) ? {16'h0000, ien_q[p]} :
                          (ofs == PCU_OFS_IRQ_FLAGS) ? {16'h0000, iflag_q[p]} :
                          (ofs == PCU_OFS_IRQ_TRIG) ? trig_q[p] :
                          (ofs == PCU_OFS_DBCLK) ? (dbclk_q[p] & PCU_DBCLK_MASK) : 32'h0000_0000;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          func_q[p] <= FUNC_RST;
          type_q[p] <= TYPE_RST;
          pull_q[p] <= '0;
          deb_q[p] <= '0;
          ien_q[p] <= '0;
          trig_q[p] <= 32'h0000_0000;
          dbclk_q[p] <= PCU_DBCLK_RST;
        end else if (wr_bank) begin
          if (ofs == PCU_OFS_FUNC) func_q[p] <= merge(func_q[p], pwdata, wmask);
          if (ofs == PCU_OFS_TYPE) type_q[p] <= merge(type_q[p], pwdata, wmask);
          if (ofs == PCU_OFS_PULLUP) pull_q[p] <= (pull_q[p] & ~wmask[NPINS-1:0]) | wlo;
          if (ofs == PCU_OFS_DEBOUNCE) deb_q[p] <= (deb_q[p] & ~wmask[NPINS-1:0]) | wlo;
          if (ofs == PCU_OFS_IRQ_EN) ien_q[p] <= (ien_q[p] & ~wmask[NPINS-1:0]) | wlo;
          if (ofs == PCU_OFS_IRQ_TRIG) trig_q[p] <= merge(trig_q[p], pwdata, wmask);
          if (ofs == PCU_OFS_DBCLK) dbclk_q[p] <= merge(dbclk_q[p], pwdata, wmask) & PCU_DBCLK_MASK;
        end
      end

      // Sticky flags: write one clears, a new event wins
      wire [NPINS-1:0] clr = (wr_bank && ofs == PCU_OFS_IRQ_FLAGS) ? wlo : '0;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          iflag_q[p] <= '0;
        end else begin
          iflag_q[p] <= (iflag_q[p] & ~clr) | evt[p];
        end
      end

      pcu_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ring_tick(ring_tick),
        .xtal_tick(xtal_tick),
        .src_sel(dbclk_q[p][PCU_DBSRC_LSB+2:PCU_DBSRC_LSB]),
        .div_n(dbclk_q[p][PCU_DBDIV_LSB+7:PCU_DBDIV_LSB]),
        .tick(tick[p])
      );

      for (b = 0; b < NPINS; b++) begin : g_pin
        localparam int I = p * NPINS + b;
        wire [1:0] fn = func_q[p][2*b+1:2*b];
        wire [1:0] ty = type_q[p][2*b+1:2*b];
        wire is_analog = (ty == PCU_TY_ANALOG);
        wire drv_val = (fn == PCU_FN_GPIO) ? gpio_out[I] : alt_out[I*3 + fn - 1];
        wire drv_req = (fn == PCU_FN_GPIO) ? 1'b1 : alt_oe[I*3 + fn - 1];
        wire filt;
        wire pevt;

        // Push-pull drives both levels, open drain drives low only
        assign pad_out[I] = (ty == PCU_TY_OPENDRAIN) ? 1'b0 : drv_val;
        assign pad_oe[I] = port_on && drv_req &&
                           ((ty == PCU_TY_PUSHPULL) || (ty == PCU_TY_OPENDRAIN && !drv_val));
        assign pad_pullup[I] = port_on && pull_q[p][b] && !is_analog;
        assign pad_analog[I] = is_analog;
        assign pin_function[2*I+1:2*I] = fn;
        assign pin_in[I] = port_on && !is_analog && filt;
        // Status records every event of a non-analog pin on an enabled port; the enable only masks the interrupt line
        assign evt[p][b] = port_on && !is_analog && pevt;

        pcu_pin u_pin (
          .pclk(pclk),
          .presetn(presetn),
          .pad_in(pad_in[I]),
          .deb_en(deb_q[p][b]),
          .deb_tick(tick[p]),
          .trig(trig_q[p][2*b+1:2*b]),
          .filt(filt),
          .event_pulse(pevt)
        );
      end
    end
  endgenerate

  logic irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(iflag_q & ien_q);
    end
  end
  assign irq = irq_q;
endmodule : pcu_top

// ### tb/pcu_checker.sv
// Assertions on the port control unit top-level ports
`timescale 1ns/10ps
module pcu_checker
  import pcu_pkg::*;
#(
  parameter int NPORTS = PCU_PORTS,
  parameter int NPINS = PCU_PINS
) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pads and selectors
  input wire logic [NPORTS*NPINS-1:0] pad_oe,
  input wire logic [NPORTS*NPINS-1:0] pad_pullup,
  input wire logic [NPORTS*NPINS-1:0] pad_analog,
  input wire logic [NPORTS*NPINS*2-1:0] pin_function
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire in_bank = paddr[31:10] == 22'h100004 && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
  AST_READY: assert property (psel |-> pready) else $error("pready low in transfer");
  AST_ERR_PHASE: assert property (pslverr |-> acc) else $error("pslverr outside access");
  AST_UNMAPPED: assert property (acc && paddr == 32'h4000_1020 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("hole not refused");
  AST_BANK_OK: assert property (acc && in_bank |-> !pslverr) else $error("bank slot refused");
  AST_FUNC_WR: assert property (acc && pwrite && paddr == 32'h4000_1000 && pstrb == 4'hF
    |=> pin_function[31:0] == $past(pwdata)) else $error("selector not written");
  AST_FUNC_HOLD: assert property (!(acc && pwrite) |=> $stable(pin_function)) else $error("selector moved");
  AST_ANA_NOOE: assert property ((pad_analog & pad_oe) == '0) else $error("analog pad driven");
  AST_ANA_NOPU: assert property ((pad_analog & pad_pullup) == '0) else $error("analog pad pulled");
  AST_RST_C: assert property ($rose(presetn) |-> pin_function[95:64] == PCU_FUNC_RST_C)
    else $error("port C default wrong");
endmodule : pcu_checker
bind pcu_top pcu_checker #(.NPORTS(NPORTS), .NPINS(NPINS)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
  .pad_analog(pad_analog), .pin_function(pin_function));

// ### tb/pcu_pad_model.sv
// Pad ring model resolving the level seen at each pin
`timescale 1ns/10ps
module pcu_pad_model #(
  parameter int W = 64
) (
  // Design side
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pad_pullup,
  // Outside drivers
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  // Resolved level
  output logic [W-1:0] pad_in
);
  // Floating pad: pull-up, else not the last driven value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pullup | ~pad_out));
endmodule : pcu_pad_model

// ### tb/pcu_top_tb.sv
// Self-checking bench of the port control unit
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module pcu_top_tb
  import pcu_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ring_tick = 0, xtal_tick = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, d, bm, a;
  logic [3:0] pstrb = '0, s, port_enable = '0, port_clk_enable = '0;
  logic pready, pslverr, irq, er;
  logic [63:0] pad_in, pad_out, pad_oe, pad_pullup, pad_analog, pin_in, gpio_out = '0, ext_en = '0, ext_val = '0;
  logic [127:0] pin_function;
  logic [191:0] alt_out = '0, alt_oe = '0;
  logic [31:0] mdl [4][8];
  logic [31:0] msk [8] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF_FFFF, 32'h7FF};
  int seed = 49613, failures = 0, comparisons = 0;
  pcu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_enable(port_enable), .port_clk_enable(port_clk_enable), .ring_tick(ring_tick),
    .xtal_tick(xtal_tick), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .pad_analog(pad_analog), .pin_function(pin_function), .alt_out(alt_out), .alt_oe(alt_oe),
    .gpio_out(gpio_out), .pin_in(pin_in), .irq(irq));
  pcu_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Peripheral side and source ticks stay busy
  always @(posedge pclk) begin
    ring_tick <= 1'($random(seed));
    xtal_tick <= 1'($random(seed));
    alt_out <= {6{$random(seed)}};
    alt_oe <= {6{$random(seed)}};
    gpio_out <= {2{$random(seed)}};
  end
  task summarize;
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [31:0] ad, dt, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [31:0] ad, dt);
    apb(1'b1, ad, dt, 4'hF);
    @(negedge pclk);
  endtask : wr
  task automatic rdc(input logic [31:0] ad, ex);
    apb(1'b0, ad, 32'h0, 4'h0);
    `CHK(rd, ex)
  endtask : rdc
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(negedge pclk);
  endtask : wait_irq
  initial begin
    #500000;
    failures++;
    summarize();
  end
  initial begin
    for (int p = 0; p < 4; p++) begin
      mdl[p] = '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    end
    mdl[2][0] = PCU_FUNC_RST_C;
    mdl[2][1] = PCU_TYPE_RST_C;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int o = 0; o < 8; o++) begin
        a = 32'h4000_1000 + p * 256 + o * 4;
        rdc(a, mdl[p][o]);
        d = $random(seed);
        s = 4'($random(seed));
        apb(1'b1, a, d, s);
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (o == 5) mdl[p][o] = mdl[p][o] & ~(d & bm);
        else mdl[p][o] = ((mdl[p][o] & ~bm) | (d & bm)) & msk[o];
        rdc(a, mdl[p][o]);
      end
    end
    apb(1'b1, 32'h4000_1020, 32'hFFFF_FFFF, 4'hF);
    `CHK(er, 1'b1)
    rdc(32'h4000_1020, 32'h0);
    `CHK(er, 1'b1)
    ext_en[0] <= 1'b1;
    port_enable <= 4'h1;
    port_clk_enable <= 4'h1;
    wr(32'h4000_1000, 32'h0);
    wr(32'h4000_1004, 32'hFFFF_FFFE);
    wr(32'h4000_100C, 32'h0);
    wr(32'h4000_1018, 32'h0);
    wr(32'h4000_1008, 32'h1);
    wr(32'h4000_1010, 32'h1);
    wr(32'h4000_1014, 32'hFFFF);
    `CHK(pad_analog[1:0], 2'b10)
    `CHK(pad_pullup[0], 1'b1)
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    @(posedge pclk);
    ext_val[0] <= 1'b1;
    wait_irq(20);
    `CHK(irq, 1'b1)
    `CHK(pin_in[0], 1'b1)
    rdc(32'h4000_1014, 32'h1);
    wr(32'h4000_1014, 32'h1);
    repeat (3) @(negedge pclk);
    `CHK(irq, 1'b0)
    wr(32'h4000_1010, 32'h0);
    wr(32'h4000_101C, 32'h0000_0400);
    wr(32'h4000_100C, 32'h1);
    @(posedge pclk);
    ext_val[0] <= 1'b0;
    @(posedge pclk);
    ext_val[0] <= 1'b1;
    repeat (12) @(negedge pclk);
    rdc(32'h4000_1014, 32'h0);
    ext_val[0] <= 1'b0;
    repeat (12) @(negedge pclk);
    @(posedge pclk);
    ext_val[0] <= 1'b1;
    repeat (12) @(negedge pclk);
    rdc(32'h4000_1014, 32'h1);
    `CHK(irq, 1'b0)
    // Level trigger keeps setting the flag, so a clear loses
    wr(32'h4000_1018, 32'h3);
    wr(32'h4000_1014, 32'h1);
    rdc(32'h4000_1014, 32'h1);
    wr(32'h4000_1018, 32'h1);
    wr(32'h4000_1014, 32'h1);
    rdc(32'h4000_1014, 32'h0);
    ext_val[0] <= 1'b0;
    repeat (12) @(negedge pclk);
    rdc(32'h4000_1014, 32'h1);
    @(negedge pclk);
    `CHK(pad_out[0], gpio_out[0])
    wr(32'h4000_1000, 32'h0000_0008);
    wr(32'h4000_1004, 32'hFFFF_FFF2);
    `CHK(pad_out[1], alt_out[4])
    `CHK(pad_oe[1], alt_oe[4])
    wr(32'h4000_1004, 32'hFFFF_FFF6);
    `CHK(pad_out[1], 1'b0)
    `CHK(pad_oe[1], alt_oe[4] & ~alt_out[4])
    summarize();
  end
endmodule : pcu_top_tb
